// file: src/escl_regs.vh
// Purpose: constants for the encoder startup configuration loader
// Assumes: 32-bit apb data, byte addresses, one word per register
// Notes: offsets and timing counts shared by design and bench
//
// Functional notes
// - switches sampled only at startup; later changes ignored until next reset
// - adopt switches only if changed since last reset, else keep stored ids
// - node number: switches one to five give bits 0-4, bits 5-6 zero
// - switch node number zero is replaced by node number one
// - accepted changed node number resets all communication ids to defaults
// - switches six to eight select 1000,800,500,250,125,50,20,10 kbit/s
// - error led dark with valid position, blinking on wrong position
// - bus led dark on lost master, blinks preop, lit operational
// - after power-on initialise, then enter pre-operational state
// - copy stored parameters at init; load defaults if never programmed
`ifndef ESCL_REGS_VH
`define ESCL_REGS_VH
`define ESCL_OFF_CTRL 12'h000
`define ESCL_OFF_STATUS 12'h004
`define ESCL_OFF_NODE 12'h008
`define ESCL_OFF_RATE 12'h00c
`define ESCL_OFF_SWITCH 12'h010
// ctrl fields
`define ESCL_CTRL_OPER 0
`define ESCL_CTRL_LOST 1
`define ESCL_CTRL_POS_BAD 2
// status fields
`define ESCL_ST_DONE 0
`define ESCL_ST_ADOPT 1
`define ESCL_ST_DEFAULTS 2
`define ESCL_ST_COMM_RST 3
// nmt state codes
`define ESCL_NMT_INIT 2'h0
`define ESCL_NMT_PREOP 2'h1
`define ESCL_NMT_OPER 2'h2
// blink half period
`define ESCL_BLINK_MS 200
`define ESCL_CLK_MHZ 250
// startup timing and output reset values
`define ESCL_SYNC_LAST 3'h3
`define ESCL_RST_NODE 7'h01
`define ESCL_RST_RATE 3'h0
`define ESCL_RST_KBPS 10'h3e8
`endif

// file: src/escl_loader.v
// Purpose: startup switch sampling, parameter load, nmt start and led drive
// Assumes: nonvolatile memory reached by a simple req/ack word port
// Notes: apb slave, zero wait states, unmapped addresses read zero and pslverr
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "escl_regs.vh"
module escl_loader #(
  parameter BLINK_CYCLES = `ESCL_BLINK_MS * 1000 * `ESCL_CLK_MHZ
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // configuration switches, asynchronous
  input wire [7:0] config_switch_bank,
  // nonvolatile memory: word 0 is stored switch copy, bit 8 set when programmed
  output reg nvm_req,
  output reg nvm_we,
  output reg [8:0] nvm_wdata,
  input wire nvm_ack,
  input wire [8:0] nvm_rdata,
  // results
  output reg [6:0] node_id,
  output reg [2:0] rate_code,
  output reg [9:0] rate_kbps,
  output reg comm_ids_default,
  output reg params_default,
  output reg can_enable,
  output reg [1:0] nmt_state,
  // indicators
  output reg err_led,
  output reg bus_led
);
  localparam ST_SYNC = 3'h0;
  localparam ST_READ = 3'h1;
  localparam ST_DECIDE = 3'h2;
  localparam ST_WRITE = 3'h3;
  localparam ST_RUN = 3'h4;
  reg [2:0] state_reg;
  reg [2:0] sync_cnt_reg;
  reg [7:0] sw_meta_reg;
  reg [7:0] sw_sync_reg;
  reg [7:0] sw_snap_reg;
  reg [8:0] nvm_word_reg;
  reg adopt_reg;
  reg oper_reg;
  reg lost_reg;
  reg pos_bad_reg;
  reg [31:0] blink_cnt_reg;
  reg blink_reg;
  wire wr_en = psel & penable & pwrite;
  wire done = (state_reg == ST_RUN);

  function [9:0] rate_of;
    input [2:0] code;
    begin
      case (code)
        3'h0: rate_of = 10'h3e8;
        3'h1: rate_of = 10'h320;
        3'h2: rate_of = 10'h1f4;
        3'h3: rate_of = 10'h0fa;
        3'h4: rate_of = 10'h07d;
        3'h5: rate_of = 10'h032;
        3'h6: rate_of = 10'h014;
        default: rate_of = 10'h00a;
      endcase
    end
  endfunction

  function [6:0] node_of;
    input [4:0] sw;
    begin
      if (sw == 5'h00) begin
        node_of = 7'h01;
      end else begin
        node_of = {2'b00, sw};
      end
    end
  endfunction

  // switch synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_meta_reg <= 8'h00;
      sw_sync_reg <= 8'h00;
    end else if (clk_en) begin
      sw_meta_reg <= config_switch_bank;
      sw_sync_reg <= sw_meta_reg;
    end
  end

  // startup sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_SYNC;
      sync_cnt_reg <= 3'h0;
      sw_snap_reg <= 8'h00;
      nvm_word_reg <= 9'h000;
      adopt_reg <= 1'b0;
      nvm_req <= 1'b0;
      nvm_we <= 1'b0;
      nvm_wdata <= 9'h000;
      node_id <= `ESCL_RST_NODE;
      rate_code <= `ESCL_RST_RATE;
      rate_kbps <= `ESCL_RST_KBPS;
      comm_ids_default <= 1'b0;
      params_default <= 1'b0;
      can_enable <= 1'b0;
      nmt_state <= `ESCL_NMT_INIT;
    end else if (clk_en) begin
      case (state_reg)
        ST_SYNC: begin
          sync_cnt_reg <= sync_cnt_reg + 3'h1;
          // wait until the synchroniser holds settled switch levels
          if (sync_cnt_reg == `ESCL_SYNC_LAST) begin
            sw_snap_reg <= sw_sync_reg;
            nvm_req <= 1'b1;
            nvm_we <= 1'b0;
            state_reg <= ST_READ;
          end
        end
        ST_READ: begin
          if (nvm_ack) begin
            nvm_req <= 1'b0;
            nvm_word_reg <= nvm_rdata;
            state_reg <= ST_DECIDE;
          end
        end
        ST_DECIDE: begin
          // an unprogrammed memory counts as a change, so ids and parameters default
          params_default <= ~nvm_word_reg[8];
          adopt_reg <= ~nvm_word_reg[8] | (nvm_word_reg[7:0] != sw_snap_reg);
          node_id <= node_of(sw_snap_reg[4:0]);
          rate_code <= sw_snap_reg[7:5];
          rate_kbps <= rate_of(sw_snap_reg[7:5]);
          comm_ids_default <= ~nvm_word_reg[8] |
            (nvm_word_reg[4:0] != sw_snap_reg[4:0]);
          nvm_req <= 1'b1;
          nvm_we <= 1'b1;
          nvm_wdata <= {1'b1, sw_snap_reg};
          state_reg <= ST_WRITE;
        end
        ST_WRITE: begin
          if (nvm_ack) begin
            nvm_req <= 1'b0;
            nvm_we <= 1'b0;
            can_enable <= 1'b1;
            nmt_state <= `ESCL_NMT_PREOP;
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (oper_reg) begin
            nmt_state <= `ESCL_NMT_OPER;
          end else begin
            nmt_state <= `ESCL_NMT_PREOP;
          end
        end
        default: begin
          state_reg <= ST_SYNC;
        end
      endcase
    end
  end

  // software control bits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oper_reg <= 1'b0;
      lost_reg <= 1'b0;
      pos_bad_reg <= 1'b0;
    end else if (clk_en && wr_en && paddr == `ESCL_OFF_CTRL) begin
      oper_reg <= pwdata[`ESCL_CTRL_OPER] & done;
      lost_reg <= pwdata[`ESCL_CTRL_LOST];
      pos_bad_reg <= pwdata[`ESCL_CTRL_POS_BAD];
    end
  end

  // blink timebase and leds
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_reg <= 1'b0;
      err_led <= 1'b0;
      bus_led <= 1'b0;
    end else if (clk_en) begin
      if (blink_cnt_reg >= BLINK_CYCLES - 1) begin
        blink_cnt_reg <= 32'h0000_0000;
        blink_reg <= ~blink_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
      end
      err_led <= pos_bad_reg & blink_reg;
      if (!done || lost_reg) begin
        bus_led <= 1'b0;
      end else if (nmt_state == `ESCL_NMT_OPER) begin
        bus_led <= 1'b1;
      end else begin
        bus_led <= blink_reg;
      end
    end
  end

  // apb read
  wire mapped = (paddr == `ESCL_OFF_CTRL) || (paddr == `ESCL_OFF_STATUS) ||
    (paddr == `ESCL_OFF_NODE) || (paddr == `ESCL_OFF_RATE) ||
    (paddr == `ESCL_OFF_SWITCH);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      case (paddr)
        `ESCL_OFF_CTRL: prdata <= {29'h0, pos_bad_reg, lost_reg, oper_reg};
        `ESCL_OFF_STATUS: prdata <= {28'h0, comm_ids_default, params_default,
          adopt_reg, done};
        `ESCL_OFF_NODE: prdata <= {25'h0, node_id};
        `ESCL_OFF_RATE: prdata <= {19'h0, rate_kbps, rate_code};
        `ESCL_OFF_SWITCH: prdata <= {24'h0, sw_snap_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // escl_loader

// file: bench/escl_monitor_monitor.sv
// Purpose: port checker for the startup loader
// Assumes: one pclk domain
// Notes: bound to the loader
`timescale 1ns/1ps
module escl_monitor (
  // clock and reset
  input logic pclk,
  input logic presetn,
  // memory port
  input logic nvm_req,
  input logic nvm_we,
  input logic nvm_ack,
  input logic [8:0] nvm_wdata,
  // results
  input logic [6:0] node_id,
  input logic can_enable,
  input logic [1:0] nmt_state,
  input logic bus_led
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_node_hi; node_id[6:5] == 2'h0; endproperty
  property p_node_nz; node_id != 7'h00; endproperty
  property p_gate; $rose(can_enable) |-> $past(nvm_ack) && $past(nvm_we); endproperty
  property p_preop; $rose(can_enable) |-> nmt_state == 2'h1; endproperty
  property p_hold; can_enable |=> $stable(node_id); endproperty
  property p_req; nvm_req && !nvm_ack |=> nvm_req; endproperty
  property p_wprog; nvm_req && nvm_we |-> nvm_wdata[8]; endproperty
  property p_dark; !can_enable |-> !bus_led; endproperty
  a_node_hi: assert property (p_node_hi) else $error("node high bits");
  a_node_nz: assert property (p_node_nz) else $error("node zero");
  a_gate: assert property (p_gate) else $error("early enable");
  a_preop: assert property (p_preop) else $error("not preop");
  a_hold: assert property (p_hold) else $error("node moved");
  a_req: assert property (p_req) else $error("req dropped");
  a_wprog: assert property (p_wprog) else $error("bad store");
  a_dark: assert property (p_dark) else $error("bus lit");
  c_start: cover property ($rose(can_enable));
  c_store: cover property (nvm_req && nvm_we && nvm_ack);
  c_oper: cover property (nmt_state == 2'h2);
endmodule // escl_monitor
bind escl_loader escl_monitor u_mon (.*);

// file: bench/escl_nvm_model.sv
// Purpose: nonvolatile memory partner
// Assumes: contents survive reset, start unprogrammed
// Notes: read data toggles between answers
`timescale 1ns/1ps
module escl_nvm_model (
  // clock and latency
  input logic pclk,
  input logic [3:0] lat,
  // word port
  input logic nvm_req,
  input logic nvm_we,
  input logic [8:0] nvm_wdata,
  output logic nvm_ack = 1'b0,
  output logic [8:0] nvm_rdata = 9'h000
);
  logic [8:0] mem_reg = 9'h000;
  logic [3:0] cnt_reg = 4'h0;
  always @(posedge pclk) begin
    nvm_ack <= 1'b0;
    nvm_rdata <= ~nvm_rdata;
    if (nvm_req && !nvm_ack) begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg >= lat) begin
        nvm_ack <= 1'b1;
        cnt_reg <= 4'h0;
        if (nvm_we) mem_reg <= nvm_wdata;
        else nvm_rdata <= mem_reg;
      end
    end
  end
endmodule // escl_nvm_model

// file: bench/tb_top.sv
// Purpose: self-checking bench for the startup loader
// Assumes: clk_en high, short blink period
// Notes: each startup is a fresh reset, memory kept
`timescale 1ns/1ps
`include "escl_regs.vh"
module tb_top;
  logic pclk = 1'b0;
  logic presetn, clk_en, psel, penable, pwrite, pready, pslverr, e;
  logic nvm_req, nvm_we, nvm_ack, can_enable, cid, pdef, err_led, bus_led;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [8:0] nvm_wdata, nvm_rdata;
  logic [7:0] sw;
  logic [6:0] node_id;
  logic [3:0] lat, v;
  logic [2:0] rate_code;
  logic [9:0] rate_kbps;
  logic [1:0] nmt_state;
  int bad_count = 0;
  int total_checks = 0;
  logic [9:0] kb [8] = '{10'h3e8, 10'h320, 10'h1f4, 10'h0fa, 10'h07d, 10'h032, 10'h014, 10'h00a};
  always #2 pclk = ~pclk;
  escl_loader #(.BLINK_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .config_switch_bank(sw),
    .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_wdata(nvm_wdata), .nvm_ack(nvm_ack),
    .nvm_rdata(nvm_rdata), .node_id(node_id), .rate_code(rate_code), .rate_kbps(rate_kbps),
    .comm_ids_default(cid), .params_default(pdef), .can_enable(can_enable),
    .nmt_state(nmt_state), .err_led(err_led), .bus_led(bus_led));
  escl_nvm_model u_nvm (.pclk(pclk), .lat(lat), .nvm_req(nvm_req), .nvm_we(nvm_we),
    .nvm_wdata(nvm_wdata), .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata));
  task complete_run;
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task start(input logic [7:0] s, input logic [3:0] l);
    @(posedge pclk);
    sw <= s;
    lat <= l;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (300) if (can_enable !== 1'b1) @(posedge pclk);
    #1;
    chk(can_enable, 1'b1);
  endtask
  // collects {err high, err low, bus high, bus low} over three blink half periods
  task obs(output logic [3:0] o);
    o = 4'h0;
    repeat (3) @(posedge pclk);
    repeat (12) begin
      @(posedge pclk);
      #1;
      o = o | {err_led, !err_led, bus_led, !bus_led};
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, sw, lat} = '0;
    clk_en = 1'b1;
    start(8'h00, 4'h0);
    chk(node_id, 7'h01);
    chk({pdef, cid}, 2'h3);
    chk(nmt_state, `ESCL_NMT_PREOP);
    apb(1'b0, `ESCL_OFF_STATUS, 32'h0);
    chk(r, 32'hf);
    // every rate code with a legal node number; no cycle time is configured
    for (int c = 0; c < 8; c++) begin
      start({c[2:0], 5'h09}, c[3:0]);
      chk({cid, node_id}, {c == 0, 7'h09});
      chk({rate_kbps, rate_code}, {kb[c], c[2:0]});
      apb(1'b0, `ESCL_OFF_RATE, 32'h0);
      chk(r, {kb[c], c[2:0]});
      apb(1'b0, `ESCL_OFF_STATUS, 32'h0);
      chk(r, {28'h0, c == 0, 3'h3});
    end
    start(8'he9, 4'h9);
    apb(1'b0, `ESCL_OFF_STATUS, 32'h0);
    chk(r, 32'h1);
    sw <= 8'h1f;
    apb(1'b0, `ESCL_OFF_SWITCH, 32'h0);
    chk(r, 32'he9);
    chk(node_id, 7'h09);
    apb(1'b1, 12'h020, 32'h1);
    chk({e, nmt_state}, {1'b1, `ESCL_NMT_PREOP});
    obs(v);
    chk(v, 4'h7);
    apb(1'b1, `ESCL_OFF_CTRL, 32'h4);
    obs(v);
    chk(v, 4'hf);
    apb(1'b1, `ESCL_OFF_CTRL, 32'h1);
    obs(v);
    chk({v, nmt_state}, {4'h6, `ESCL_NMT_OPER});
    apb(1'b1, `ESCL_OFF_CTRL, 32'h3);
    obs(v);
    chk(v, 4'h5);
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    complete_run;
  end
endmodule // tb_top
